// file: pkg/decoder_regs.vh
// Constants for the fourteen-bit instruction decoder
`ifndef DECODER_REGS_VH
`define DECODER_REGS_VH

// Instruction word geometry
`define WORD_W              14
`define FILE_ADDR_W         7
`define LIT_W               11
`define OP_W                6

// Timing
`define OSC_PER_CYCLE       3'h4
`define PHASE_LAST          2'h3

// Indirect file register addresses
`define INDIRECT_ADDR0      7'h00
`define INDIRECT_ADDR1      7'h01

// Operation codes
`define OP_NO_OPERATION             6'h00
`define OP_SOFT_RESET               6'h01
`define OP_SUB_RETURN               6'h02
`define OP_RETURN_FROM_INTERRUPT    6'h03
`define OP_CALL_BY_WORK_REG         6'h04
`define OP_BRANCH_BY_WORK_REG       6'h05
`define OP_POINTER_LOAD             6'h06
`define OP_POINTER_STORE            6'h07
`define OP_LOAD_BANK_SELECT         6'h08
`define OP_LOAD_OPTION              6'h09
`define OP_ENTER_STANDBY            6'h0a
`define OP_WATCHDOG_CLEAR           6'h0b
`define OP_LOAD_DIRECTION_REG       6'h0c
`define OP_MOVE_W_TO_REG            6'h0d
`define OP_CLEAR_WORK_REG           6'h0e
`define OP_CLEAR_REG                6'h0f
`define OP_SUB_W_FROM_REG           6'h10
`define OP_DECREMENT_REG            6'h11
`define OP_OR_W_WITH_REG            6'h12
`define OP_AND_W_WITH_REG           6'h13
`define OP_XOR_W_WITH_REG           6'h14
`define OP_ADD_W_TO_REG             6'h15
`define OP_MOVE_REG                 6'h16
`define OP_COMPLEMENT_REG           6'h17
`define OP_INCREMENT_REG            6'h18
`define OP_DECREMENT_SKIP_ZERO      6'h19
`define OP_ROTATE_RIGHT_CARRY       6'h1a
`define OP_ROTATE_LEFT_CARRY        6'h1b
`define OP_SWAP_NIBBLES             6'h1c
`define OP_INCREMENT_SKIP_ZERO      6'h1d
`define OP_BIT_CLEAR_OP             6'h1e
`define OP_BIT_SET_OP               6'h1f
`define OP_BIT_TEST_SKIP_CLEAR      6'h20
`define OP_BIT_TEST_SKIP_SET        6'h21
`define OP_ABS_CALL                 6'h22
`define OP_ABSOLUTE_JUMP            6'h23
`define OP_MOVE_LITERAL             6'h24
`define OP_POINTER_ADD              6'h25
`define OP_LOAD_PC_LATCH            6'h26
`define OP_RELATIVE_BRANCH          6'h27
`define OP_RETURN_WITH_LITERAL      6'h28
`define OP_LOGIC_SHIFT_LEFT_REG     6'h29
`define OP_LOGIC_SHIFT_RIGHT_REG    6'h2a
`define OP_ARITH_SHIFT_RIGHT_REG    6'h2b
`define OP_OR_LITERAL               6'h2c
`define OP_AND_LITERAL              6'h2d
`define OP_XOR_LITERAL              6'h2e
`define OP_SUBTRACT_WITH_BORROW     6'h2f
`define OP_SUBTRACT_FROM_LITERAL    6'h30
`define OP_ADD_W_REG_CARRY          6'h31
`define OP_ADD_LITERAL              6'h32
`define OP_INDEXED_LOAD             6'h33
`define OP_INDEXED_STORE            6'h34
`define OP_UNDEFINED                6'h35

`endif

// file: verilog/cycle_phase_counter.v
// Divides the oscillator clock into four-phase instruction cycles
`timescale 1ns/1ps
`include "decoder_regs.vh"
module cycle_phase_counter
(
  // Clock and reset
  input  wire       clock,
  input  wire       reset_n,
  // Phase outputs
  output wire [1:0] phase,
  output wire       cycle_end
);

  reg [1:0] phase_q;
  wire [1:0] phase_d;

  assign phase_d   = phase_q + 2'h1;
  assign phase     = phase_q;
  assign cycle_end = (phase_q == `PHASE_LAST);

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      phase_q <= 2'h0;
    else
      phase_q <= phase_d;
  end

endmodule // cycle_phase_counter

// file: verilog/instruction_decoder.v
// Fourteen-bit instruction decoder with instruction-cycle timing
//
// Behaviour
// - Each 14-bit word holds opcode and all operands; no operand fetch.
// - One instruction cycle is four oscillator clocks.
// - Absolute call and call through working register take two cycles.
// - Interrupt return, literal return and plain return take two cycles.
// - Absolute jump, relative branch, branch by working register take two cycles.
// - Skips and PC-writing ops take one cycle, two when condition true.
// - Indirect access with pointer MSB set adds one instruction cycle.
// - File-register instructions read the register first, then store result.
// - Destination bit 0 selects working register, 1 selects file register.
// - File address is seven bits in the word's low bits.
// - Decode byte operations add, add carry, and, shifts, complement, dec, inc.
// - Decode or, move, rotates, borrow subtract, swap, xor, both clears.
// - Decrement and increment skip-if-zero write result and skip on zero.
// - Bit operations use 01, two-bit op, bit index 9:7, address.
// - Decode the six eight-bit literal operations by their prefixes.
// - Decode bank-select load and program-counter latch load literals.
// - Decode relative branch and branch by working register.
// - Decode absolute call, absolute jump and call through working register.
// - Decode interrupt return, plain return and return with literal.
// - Decode no-op, soft reset, option load, watchdog, standby, direction load.
// - Only watchdog clear and standby touch time-out and power-down flags.
// - Decode pointer add, pointer moves with modes and indexed moves.
`timescale 1ns/1ps
`include "decoder_regs.vh"
module instruction_decoder
(
  // Clock and reset
  input  wire                    clock,
  input  wire                    reset_n,
  // Program memory word
  input  wire [`WORD_W-1:0]      instr_word,
  output wire                    fetch_take,
  // Datapath feedback
  input  wire [1:0]              pointer_msb,
  input  wire                    branch_cond,
  // Cycle timing
  output wire [1:0]              phase,
  output wire                    cycle_end,
  output wire                    busy,
  output reg                     idle_cycle_q,
  output reg  [1:0]              base_cycles_q,
  // Decoded operation
  output reg  [`OP_W-1:0]        op_q,
  output reg  [`FILE_ADDR_W-1:0] file_addr_q,
  output reg  [2:0]              bit_index_q,
  output reg  [`LIT_W-1:0]       literal_q,
  output reg                     pointer_sel_q,
  output reg  [1:0]              pointer_mode_q,
  output reg                     reads_file_q,
  output reg                     dest_is_file_q,
  output reg                     dest_is_work_q,
  output reg                     indirect_q,
  // Status flag update enables
  output reg                     upd_carry_q,
  output reg                     upd_digit_carry_q,
  output reg                     upd_zero_q,
  output reg                     upd_timeout_powerdown_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Phase divider

  cycle_phase_counter u_phase
  (
    .clock     (clock),
    .reset_n   (reset_n),
    .phase     (phase),
    .cycle_end (cycle_end)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Opcode match

  reg [`OP_W-1:0] op_d;

  always @*
  begin
    op_d = `OP_UNDEFINED;
    casez (instr_word)
      14'b00_0000_0000_0000: op_d = `OP_NO_OPERATION;
      14'b00_0000_0000_0001: op_d = `OP_SOFT_RESET;
      14'b00_0000_0000_1000: op_d = `OP_SUB_RETURN;
      14'b00_0000_0000_1001: op_d = `OP_RETURN_FROM_INTERRUPT;
      14'b00_0000_0000_1010: op_d = `OP_CALL_BY_WORK_REG;
      14'b00_0000_0000_1011: op_d = `OP_BRANCH_BY_WORK_REG;
      14'b00_0000_0001_0???: op_d = `OP_POINTER_LOAD;
      14'b00_0000_0001_1???: op_d = `OP_POINTER_STORE;
      14'b00_0000_001?_????: op_d = `OP_LOAD_BANK_SELECT;
      14'b00_0000_0110_0010: op_d = `OP_LOAD_OPTION;
      14'b00_0000_0110_0011: op_d = `OP_ENTER_STANDBY;
      14'b00_0000_0110_0100: op_d = `OP_WATCHDOG_CLEAR;
      14'b00_0000_0110_0???: op_d = `OP_LOAD_DIRECTION_REG;
      14'b00_0000_1???_????: op_d = `OP_MOVE_W_TO_REG;
      14'b00_0001_0000_00??: op_d = `OP_CLEAR_WORK_REG;
      14'b00_0001_1???_????: op_d = `OP_CLEAR_REG;
      14'b00_0010_????_????: op_d = `OP_SUB_W_FROM_REG;
      14'b00_0011_????_????: op_d = `OP_DECREMENT_REG;
      14'b00_0100_????_????: op_d = `OP_OR_W_WITH_REG;
      14'b00_0101_????_????: op_d = `OP_AND_W_WITH_REG;
      14'b00_0110_????_????: op_d = `OP_XOR_W_WITH_REG;
      14'b00_0111_????_????: op_d = `OP_ADD_W_TO_REG;
      14'b00_1000_????_????: op_d = `OP_MOVE_REG;
      14'b00_1001_????_????: op_d = `OP_COMPLEMENT_REG;
      14'b00_1010_????_????: op_d = `OP_INCREMENT_REG;
      14'b00_1011_????_????: op_d = `OP_DECREMENT_SKIP_ZERO;
      14'b00_1100_????_????: op_d = `OP_ROTATE_RIGHT_CARRY;
      14'b00_1101_????_????: op_d = `OP_ROTATE_LEFT_CARRY;
      14'b00_1110_????_????: op_d = `OP_SWAP_NIBBLES;
      14'b00_1111_????_????: op_d = `OP_INCREMENT_SKIP_ZERO;
      14'b01_00??_????_????: op_d = `OP_BIT_CLEAR_OP;
      14'b01_01??_????_????: op_d = `OP_BIT_SET_OP;
      14'b01_10??_????_????: op_d = `OP_BIT_TEST_SKIP_CLEAR;
      14'b01_11??_????_????: op_d = `OP_BIT_TEST_SKIP_SET;
      14'b10_0???_????_????: op_d = `OP_ABS_CALL;
      14'b10_1???_????_????: op_d = `OP_ABSOLUTE_JUMP;
      14'b11_0000_????_????: op_d = `OP_MOVE_LITERAL;
      14'b11_0001_0???_????: op_d = `OP_POINTER_ADD;
      14'b11_0001_1???_????: op_d = `OP_LOAD_PC_LATCH;
      14'b11_001?_????_????: op_d = `OP_RELATIVE_BRANCH;
      14'b11_0100_????_????: op_d = `OP_RETURN_WITH_LITERAL;
      14'b11_0101_????_????: op_d = `OP_LOGIC_SHIFT_LEFT_REG;
      14'b11_0110_????_????: op_d = `OP_LOGIC_SHIFT_RIGHT_REG;
      14'b11_0111_????_????: op_d = `OP_ARITH_SHIFT_RIGHT_REG;
      14'b11_1000_????_????: op_d = `OP_OR_LITERAL;
      14'b11_1001_????_????: op_d = `OP_AND_LITERAL;
      14'b11_1010_????_????: op_d = `OP_XOR_LITERAL;
      14'b11_1011_????_????: op_d = `OP_SUBTRACT_WITH_BORROW;
      14'b11_1100_????_????: op_d = `OP_SUBTRACT_FROM_LITERAL;
      14'b11_1101_????_????: op_d = `OP_ADD_W_REG_CARRY;
      14'b11_1110_????_????: op_d = `OP_ADD_LITERAL;
      14'b11_1111_0???_????: op_d = `OP_INDEXED_LOAD;
      14'b11_1111_1???_????: op_d = `OP_INDEXED_STORE;
      default:               op_d = `OP_UNDEFINED;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operation attributes

  reg              file_op;
  reg              d_op;
  reg              fixed_file_dest;
  reg              fixed_work_dest;
  reg              cond_op;
  reg              two_cycle;
  reg              ptr_op;
  reg              f_c;
  reg              f_dc;
  reg              f_z;
  reg              f_tp;
  reg [`LIT_W-1:0] lit_d;

  always @*
  begin
    file_op         = 1'b0;
    d_op            = 1'b0;
    fixed_file_dest = 1'b0;
    fixed_work_dest = 1'b0;
    cond_op         = 1'b0;
    two_cycle       = 1'b0;
    ptr_op          = 1'b0;
    f_c             = 1'b0;
    f_dc            = 1'b0;
    f_z             = 1'b0;
    f_tp            = 1'b0;
    lit_d           = {`LIT_W{1'b0}};
    case (op_d)
      `OP_ADD_W_TO_REG, `OP_ADD_W_REG_CARRY, `OP_SUB_W_FROM_REG, `OP_SUBTRACT_WITH_BORROW:
      begin
        file_op = 1'b1;
        d_op    = 1'b1;
        f_c     = 1'b1;
        f_dc    = 1'b1;
        f_z     = 1'b1;
      end
      `OP_AND_W_WITH_REG, `OP_OR_W_WITH_REG, `OP_XOR_W_WITH_REG, `OP_MOVE_REG,
      `OP_COMPLEMENT_REG, `OP_DECREMENT_REG, `OP_INCREMENT_REG:
      begin
        file_op = 1'b1;
        d_op    = 1'b1;
        f_z     = 1'b1;
      end
      `OP_ROTATE_LEFT_CARRY, `OP_ROTATE_RIGHT_CARRY:
      begin
        file_op = 1'b1;
        d_op    = 1'b1;
        f_c     = 1'b1;
      end
      `OP_LOGIC_SHIFT_LEFT_REG, `OP_LOGIC_SHIFT_RIGHT_REG, `OP_ARITH_SHIFT_RIGHT_REG:
      begin
        file_op = 1'b1;
        d_op    = 1'b1;
        f_c     = 1'b1;
        f_z     = 1'b1;
      end
      `OP_SWAP_NIBBLES:
      begin
        file_op = 1'b1;
        d_op    = 1'b1;
      end
      `OP_DECREMENT_SKIP_ZERO, `OP_INCREMENT_SKIP_ZERO:
      begin
        file_op = 1'b1;
        d_op    = 1'b1;
        cond_op = 1'b1;
      end
      `OP_CLEAR_REG:
      begin
        file_op         = 1'b1;
        fixed_file_dest = 1'b1;
        f_z             = 1'b1;
      end
      `OP_MOVE_W_TO_REG, `OP_BIT_CLEAR_OP, `OP_BIT_SET_OP:
      begin
        file_op         = 1'b1;
        fixed_file_dest = 1'b1;
      end
      `OP_BIT_TEST_SKIP_CLEAR, `OP_BIT_TEST_SKIP_SET:
      begin
        file_op = 1'b1;
        cond_op = 1'b1;
      end
      `OP_CLEAR_WORK_REG:
      begin
        fixed_work_dest = 1'b1;
        f_z             = 1'b1;
      end
      `OP_ADD_LITERAL, `OP_SUBTRACT_FROM_LITERAL:
      begin
        fixed_work_dest = 1'b1;
        f_c             = 1'b1;
        f_dc            = 1'b1;
        f_z             = 1'b1;
        lit_d           = {3'h0, instr_word[7:0]};
      end
      `OP_AND_LITERAL, `OP_OR_LITERAL, `OP_XOR_LITERAL:
      begin
        fixed_work_dest = 1'b1;
        f_z             = 1'b1;
        lit_d           = {3'h0, instr_word[7:0]};
      end
      `OP_MOVE_LITERAL:
      begin
        fixed_work_dest = 1'b1;
        lit_d           = {3'h0, instr_word[7:0]};
      end
      `OP_RETURN_WITH_LITERAL:
      begin
        fixed_work_dest = 1'b1;
        two_cycle       = 1'b1;
        lit_d           = {3'h0, instr_word[7:0]};
      end
      `OP_LOAD_BANK_SELECT:
        lit_d = {6'h00, instr_word[4:0]};
      `OP_LOAD_PC_LATCH:
        lit_d = {4'h0, instr_word[6:0]};
      `OP_RELATIVE_BRANCH:
      begin
        two_cycle = 1'b1;
        lit_d     = {{2{instr_word[8]}}, instr_word[8:0]};
      end
      `OP_ABS_CALL, `OP_ABSOLUTE_JUMP:
      begin
        two_cycle = 1'b1;
        lit_d     = instr_word[10:0];
      end
      `OP_CALL_BY_WORK_REG, `OP_SUB_RETURN, `OP_RETURN_FROM_INTERRUPT,
      `OP_BRANCH_BY_WORK_REG:
        two_cycle = 1'b1;
      `OP_WATCHDOG_CLEAR, `OP_ENTER_STANDBY:
        f_tp = 1'b1;
      `OP_LOAD_DIRECTION_REG:
        lit_d = {8'h00, instr_word[2:0]};
      `OP_POINTER_ADD:
      begin
        ptr_op = 1'b1;
        lit_d  = {{5{instr_word[5]}}, instr_word[5:0]};
      end
      `OP_POINTER_LOAD:
      begin
        ptr_op          = 1'b1;
        fixed_work_dest = 1'b1;
        f_z             = 1'b1;
      end
      `OP_INDEXED_LOAD:
      begin
        ptr_op          = 1'b1;
        fixed_work_dest = 1'b1;
        f_z             = 1'b1;
        lit_d           = {{5{instr_word[5]}}, instr_word[5:0]};
      end
      `OP_POINTER_STORE:
        ptr_op = 1'b1;
      `OP_INDEXED_STORE:
      begin
        ptr_op = 1'b1;
        lit_d  = {{5{instr_word[5]}}, instr_word[5:0]};
      end
      default:
        lit_d = {`LIT_W{1'b0}};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Destination, indirection and cycle count

  wire       dest_file_d;
  wire       dest_work_d;
  wire       ind_file_d;
  wire       ind_ptr_d;
  wire       ptr_sel_d;
  wire       indirect_d;
  wire       pc_cond_d;
  wire [1:0] cycles_d;

  assign dest_file_d = fixed_file_dest | (d_op & instr_word[7]);
  assign dest_work_d = fixed_work_dest | (d_op & ~instr_word[7]);
  assign ind_file_d  = file_op & ((instr_word[6:0] == `INDIRECT_ADDR0) |
                                  (instr_word[6:0] == `INDIRECT_ADDR1));
  assign ind_ptr_d   = ptr_op & (op_d != `OP_POINTER_ADD);
  assign ptr_sel_d   = file_op ? instr_word[0] :
                       ((op_d == `OP_POINTER_LOAD) | (op_d == `OP_POINTER_STORE)) ?
                       instr_word[2] : instr_word[6];
  assign indirect_d  = (ind_file_d | ind_ptr_d) & pointer_msb[ptr_sel_d];
  assign pc_cond_d   = cond_op | dest_file_d;
  assign cycles_d    = (two_cycle ? 2'h2 : 2'h1) + {1'b0, indirect_d};

  ////////////////////////////////////////////////////////////////////////////
  // Instruction cycle sequencer

  reg  [1:0] remain_q;
  reg        first_q;
  reg        pc_cond_q;
  reg  [1:0] remain_d;
  wire       skip_now;

  assign skip_now   = first_q & pc_cond_q & branch_cond;
  assign busy       = (remain_q != 2'h0) | skip_now;
  assign fetch_take = cycle_end & ~busy;

  always @*
  begin
    remain_d = remain_q;
    if (fetch_take)
      remain_d = cycles_d - 2'h1;
    else if (cycle_end)
      remain_d = remain_q - 2'h1 + {1'b0, skip_now};
  end

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      remain_q     <= 2'h0;
      first_q      <= 1'b0;
      pc_cond_q    <= 1'b0;
      idle_cycle_q <= 1'b0;
    end
    else if (cycle_end)
    begin
      remain_q     <= remain_d;
      first_q      <= fetch_take;
      pc_cond_q    <= fetch_take ? pc_cond_d : 1'b0;
      idle_cycle_q <= ~fetch_take;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded operation registers

  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      op_q                    <= `OP_NO_OPERATION;
      file_addr_q             <= {`FILE_ADDR_W{1'b0}};
      bit_index_q             <= 3'h0;
      literal_q               <= {`LIT_W{1'b0}};
      pointer_sel_q           <= 1'b0;
      pointer_mode_q          <= 2'h0;
      reads_file_q            <= 1'b0;
      dest_is_file_q          <= 1'b0;
      dest_is_work_q          <= 1'b0;
      indirect_q              <= 1'b0;
      base_cycles_q           <= 2'h1;
      upd_carry_q             <= 1'b0;
      upd_digit_carry_q       <= 1'b0;
      upd_zero_q              <= 1'b0;
      upd_timeout_powerdown_q <= 1'b0;
    end
    else if (fetch_take)
    begin
      op_q                    <= op_d;
      file_addr_q             <= file_op ? instr_word[6:0] : {`FILE_ADDR_W{1'b0}};
      bit_index_q             <= instr_word[9:7];
      literal_q               <= lit_d;
      pointer_sel_q           <= ptr_sel_d;
      pointer_mode_q          <= instr_word[1:0];
      reads_file_q            <= file_op;
      dest_is_file_q          <= dest_file_d;
      dest_is_work_q          <= dest_work_d;
      indirect_q              <= indirect_d;
      base_cycles_q           <= cycles_d;
      upd_carry_q             <= f_c;
      upd_digit_carry_q       <= f_dc;
      upd_zero_q              <= f_z;
      upd_timeout_powerdown_q <= f_tp;
    end
  end

endmodule // instruction_decoder

// file: dv/prog_mem_model.sv
// Program memory model handing one whole instruction word per take
`timescale 1ns/1ps
`include "decoder_regs.vh"
module prog_mem_model
(
  // Clock and reset
  input  wire                 clock,
  input  wire                 reset_n,
  // Fetch handshake
  input  wire                 fetch_take,
  output wire [`WORD_W-1:0]   instr_word
);
  logic [`WORD_W-1:0] mem [0:63];
  logic [5:0]         addr_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Whole word at the take, inverted pattern while not taken
  assign instr_word = fetch_take ? mem[addr_q] : ~mem[addr_q];
  always @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      addr_q <= 6'h00;
    else if (fetch_take)
      addr_q <= addr_q + 6'h01;
  end
endmodule // prog_mem_model

// file: dv/instruction_decoder_checker.sv
// Timing and decode assertions for the instruction decoder
`timescale 1ns/1ps
`include "decoder_regs.vh"
module instruction_decoder_checker
(
  // Clock and reset
  input  wire                     clock,
  input  wire                     reset_n,
  // Inputs
  input  wire [`WORD_W-1:0]       instr_word,
  input  wire [1:0]               pointer_msb,
  input  wire                     branch_cond,
  // Timing
  input  wire                     fetch_take,
  input  wire [1:0]               phase,
  input  wire                     cycle_end,
  input  wire                     busy,
  input  wire [1:0]               base_cycles_q,
  // Decode
  input  wire [`OP_W-1:0]         op_q,
  input  wire [`FILE_ADDR_W-1:0]  file_addr_q,
  input  wire [2:0]               bit_index_q,
  input  wire [`LIT_W-1:0]        literal_q,
  input  wire                     pointer_sel_q,
  input  wire [1:0]               pointer_mode_q,
  input  wire                     reads_file_q,
  input  wire                     dest_is_file_q,
  input  wire                     dest_is_work_q,
  input  wire                     indirect_q,
  // Flags
  input  wire                     upd_carry_q,
  input  wire                     upd_digit_carry_q,
  input  wire                     upd_zero_q,
  input  wire                     upd_timeout_powerdown_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  a_take_at_phase3: assert property (
    fetch_take |-> cycle_end && !busy && phase == `PHASE_LAST) else $error("take off phase");
  a_phase_four_step: assert property (
    cycle_end |=> phase == 2'h0 ##1 phase == 2'h1 ##1 phase == 2'h2 ##1 cycle_end)
    else $error("phase sequence broken");
  a_branch_two_cycles: assert property (
    fetch_take && (instr_word[13:12] == 2'b10 || instr_word[13:9] == 5'b11001
    || instr_word[13:8] == 6'h34 || (instr_word[13:4] == 10'h000 && instr_word[3:2] == 2'b10))
    |=> !fetch_take [*7] ##1 fetch_take) else $error("control op not two cycles");
  a_literal_one_cycle: assert property (
    fetch_take && instr_word[13:12] == 2'b11 && instr_word[11:8] inside {4'h0, 4'h8, 4'h9,
    4'ha, 4'hc, 4'he} |=> !fetch_take [*3] ##1 fetch_take) else $error("literal op length");
  a_skip_true_two: assert property (
    fetch_take && instr_word[13:11] == 3'b011 && instr_word[6:1] != 6'h00 ##4 branch_cond
    |=> !fetch_take [*3] ##1 fetch_take) else $error("true skip not two cycles");
  a_skip_false_one: assert property (
    fetch_take && instr_word[13:11] == 3'b011 && instr_word[6:1] != 6'h00 ##4 !branch_cond
    |-> fetch_take) else $error("false skip not one cycle");
  a_indirect_extra: assert property (
    fetch_take && instr_word[13:7] == 7'h10 && instr_word[6:1] == 6'h00
    && pointer_msb[instr_word[0]] |=> indirect_q && base_cycles_q == 2'h2)
    else $error("indirect cycle missing");
  a_dest_select: assert property (
    fetch_take && instr_word[13:8] == 6'h07 |=> reads_file_q && file_addr_q == $past(instr_word[6:0])
    && dest_is_file_q == $past(instr_word[7]) && dest_is_work_q == !$past(instr_word[7]))
    else $error("destination decode wrong");
  a_bit_fields: assert property (
    fetch_take && instr_word[13:12] == 2'b01 |=> bit_index_q == $past(instr_word[9:7])
    && file_addr_q == $past(instr_word[6:0])) else $error("bit op fields wrong");
  a_literal_field: assert property (
    fetch_take && instr_word[13:8] == 6'h30 |=> literal_q == {3'h0, $past(instr_word[7:0])})
    else $error("literal field wrong");
  a_pointer_fields: assert property (
    fetch_take && instr_word[13:4] == 10'h001 |=> pointer_sel_q == $past(instr_word[2])
    && pointer_mode_q == $past(instr_word[1:0])) else $error("pointer fields wrong");
  a_arith_flags: assert property (
    fetch_take && instr_word[13:8] inside {6'h07, 6'h3d, 6'h3e}
    |=> upd_carry_q && upd_digit_carry_q && upd_zero_q) else $error("arith flags wrong");
  a_status_guard: assert property (
    upd_timeout_powerdown_q == (op_q == `OP_WATCHDOG_CLEAR || op_q == `OP_ENTER_STANDBY))
    else $error("time-out flags touched");
  a_undefined_nop: assert property (
    fetch_take && instr_word == 14'h0104 |=> op_q == `OP_UNDEFINED && base_cycles_q == 2'h1)
    else $error("unlisted word not a no-op");
endmodule // instruction_decoder_checker

bind instruction_decoder instruction_decoder_checker i_instruction_decoder_checker
(
  .clock(clock), .reset_n(reset_n), .instr_word(instr_word), .pointer_msb(pointer_msb),
  .branch_cond(branch_cond), .fetch_take(fetch_take), .phase(phase), .cycle_end(cycle_end),
  .busy(busy), .base_cycles_q(base_cycles_q), .op_q(op_q), .file_addr_q(file_addr_q),
  .bit_index_q(bit_index_q), .reads_file_q(reads_file_q), .dest_is_file_q(dest_is_file_q),
  .literal_q(literal_q), .pointer_sel_q(pointer_sel_q), .pointer_mode_q(pointer_mode_q),
  .dest_is_work_q(dest_is_work_q), .indirect_q(indirect_q), .upd_carry_q(upd_carry_q),
  .upd_digit_carry_q(upd_digit_carry_q), .upd_zero_q(upd_zero_q),
  .upd_timeout_powerdown_q(upd_timeout_powerdown_q)
);

// file: dv/test_instruction_decoder.sv
// Testbench stepping a program of every word kind through the decoder
`timescale 1ns/1ps
`include "decoder_regs.vh"
module test_instruction_decoder;
  logic                clock;
  logic                reset_n;
  logic [1:0]          pointer_msb;
  logic                branch_cond;
  wire  [`WORD_W-1:0]  instr_word;
  wire                 fetch_take;
  wire  [`OP_W-1:0]    op_q;
  integer              k;
  integer              n;
  integer              mismatches;
  integer              checks_done;
  // Word, op code, cycles, then condition bit 3 and pointer msbs 1:0
  logic [31:0] tbl [0:57] = '{
    32'h0000_0010, 32'h2805_2320, 32'h2005_2220, 32'h000a_0420, 32'h000b_0520, 32'h3205_2720,
    32'h0008_0220, 32'h0009_0320, 32'h3405_2820, 32'h1805_2028, 32'h1c05_2110, 32'h0b85_1928,
    32'h0f05_1d10, 32'h0800_1621, 32'h0801_1622, 32'h0801_1611, 32'h1800_2039, 32'h0780_1510,
    32'h0104_3518, 32'h0064_0b10, 32'h0063_0a10, 32'h0001_0110, 32'h0062_0910, 32'h0065_0c10,
    32'h0025_0810, 32'h3185_2610, 32'h3105_2511, 32'h0012_0610, 32'h001a_0710, 32'h3f05_3310,
    32'h3f85_3410, 32'h1005_1e10, 32'h1405_1f10, 32'h0180_0f10, 32'h0100_0e10, 32'h0705_1518,
    32'h3d05_3110, 32'h0505_1310, 32'h3705_2b10, 32'h3505_2910, 32'h3605_2a10, 32'h0905_1710,
    32'h0305_1110, 32'h0a05_1810, 32'h0405_1210, 32'h0d05_1b10, 32'h0c05_1a10, 32'h3b05_2f10,
    32'h0e05_1c10, 32'h0605_1410, 32'h3e05_3218, 32'h3905_2d10, 32'h3805_2c10, 32'h3005_2410,
    32'h3c05_3010, 32'h3a05_2e10, 32'h0085_0d10, 32'h0205_1010};
  ////////////////////////////////////////////////////////////////////////////////
  instruction_decoder i_instruction_decoder
  (
    .clock(clock), .reset_n(reset_n), .instr_word(instr_word), .fetch_take(fetch_take),
    .pointer_msb(pointer_msb), .branch_cond(branch_cond), .phase(), .cycle_end(), .busy(),
    .idle_cycle_q(), .base_cycles_q(), .op_q(op_q), .file_addr_q(), .bit_index_q(),
    .literal_q(), .pointer_sel_q(), .pointer_mode_q(), .reads_file_q(), .dest_is_file_q(),
    .dest_is_work_q(), .indirect_q(), .upd_carry_q(), .upd_digit_carry_q(), .upd_zero_q(),
    .upd_timeout_powerdown_q()
  );
  prog_mem_model i_prog_mem_model
  (
    .clock(clock), .reset_n(reset_n), .fetch_take(fetch_take), .instr_word(instr_word)
  );
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task check_op(input [`OP_W-1:0] exp, input [`OP_W-1:0] got);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("ERROR op_q expected %h seen %h", exp, got);
    end
  end
  endtask
  task check_cycles(input integer exp, input integer got);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("ERROR clocks_per_word expected %0d seen %0d", exp, got);
    end
  end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mismatches = 0;
    checks_done = 0;
    reset_n = 1'b0;
    branch_cond = 1'b0;
    pointer_msb = tbl[0][1:0];
    for (k = 0; k < 64; k++)
      i_prog_mem_model.mem[k] = (k < 58) ? tbl[k][29:16] : 14'h0000;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    n = 0;
    do begin @(negedge clock); n++; end while (fetch_take !== 1'b1 && n < 40);
    @(posedge clock);
    @(negedge clock);
    for (k = 0; k < 58; k++)
    begin
      check_op(tbl[k][13:8], op_q);
      @(posedge clock);
      branch_cond <= tbl[k][3];
      pointer_msb <= (k < 57) ? tbl[k+1][1:0] : 2'b00;
      n = 1;
      do begin @(negedge clock); n++; end while (fetch_take !== 1'b1 && n < 40);
      check_cycles(4 * tbl[k][5:4], n);
      @(posedge clock);
      @(negedge clock);
      $display("step %0d done", k);
    end
    report_and_stop;
  end
  initial
  begin
    #300000;
    mismatches = mismatches + 1;
    report_and_stop;
  end
endmodule // test_instruction_decoder
